// ===== pwp_defines.svh
`ifndef PWP_DEFINES_SVH
`define PWP_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PWP_CLK_HZ 50000000
`define PWP_STROBE_NS 1000
// Exact at 50 MHz: 1000 ns * 50 cycles per us / 1000 = 50 cycles.
`define PWP_STROBE_CYC ((`PWP_STROBE_NS * (`PWP_CLK_HZ / 1000000)) / 1000)
`define PWP_CNT_W 6

// ----------------------------------------------------------------
// Host-side register offsets (byte addresses) and reset values
// ----------------------------------------------------------------
`define PWP_OFF_CSR 3'h0
`define PWP_OFF_OUTBUF 3'h2
`define PWP_OFF_INBUF 3'h4
`define PWP_CSR_RST 16'h0000
`define PWP_OUTBUF_RST 16'h0000

// ----------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------
`define PWP_CSR_FUNC0 0
`define PWP_CSR_FUNC1 1
`define PWP_CSR_INIT 3
`define PWP_CSR_REQA 7
`define PWP_CSR_REQB 15

// ----------------------------------------------------------------
// Strobe slots in the pulse counter array
// ----------------------------------------------------------------
`define PWP_STB_NDR 0
`define PWP_STB_HI 1
`define PWP_STB_LO 2
`define PWP_STB_XMTD 3
`define PWP_STB_INIT 4
`define PWP_NSTB 5

`endif

// ===== pwp_link_checker.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Checks on the parallel word lines between the two ends.
// ----------------------------------------------------------------
module pwp_link_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] data_out,
  input wire logic new_word,
  input wire logic new_hi,
  input wire logic new_lo,
  input wire logic data_taken,
  input wire logic init_out
);
  logic [4:0] stb;
  logic [4:0][5:0] cnt_q;
  logic [4:0][5:0] cnt_d;

  assign stb = {init_out, data_taken, new_lo, new_hi, new_word};

  // High time of each strobe; it saturates at 63 so an overlong strobe cannot wrap back to 50 and pass.
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      cnt_d[i] = 6'h00;
      if (stb[i])
        cnt_d[i] = (cnt_q[i] == 6'h3F) ? cnt_q[i] : cnt_q[i] + 6'h01;
    end
  end

  // Counter register, cleared by reset.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_word_pulse_width: assert property ($fell(new_word) |-> cnt_q[0] == 6'h32)
    else $error("new word strobe not 50 cycles");
  a_hi_pulse_width: assert property ($fell(new_hi) |-> cnt_q[1] == 6'h32)
    else $error("upper byte strobe not 50 cycles");
  a_lo_pulse_width: assert property ($fell(new_lo) |-> cnt_q[2] == 6'h32)
    else $error("lower byte strobe not 50 cycles");
  a_taken_pulse_width: assert property ($fell(data_taken) |-> cnt_q[3] == 6'h32)
    else $error("acknowledge strobe not 50 cycles");
  a_init_pulse_width: assert property ($fell(init_out) |-> cnt_q[4] == 6'h32)
    else $error("initialize strobe not 50 cycles");
  a_hi_keeps_lower: assert property ($rose(new_hi) |-> data_out[7:0] == $past(data_out[7:0]))
    else $error("upper byte write touched lower lane");
  a_lo_keeps_upper: assert property ($rose(new_lo) |-> data_out[15:8] == $past(data_out[15:8]))
    else $error("lower byte write touched upper lane");
  a_word_no_bytes: assert property ($rose(new_word) |-> !new_hi && !new_lo)
    else $error("word write pulsed a byte strobe");

  c_word: cover property ($rose(new_word));
  c_hi: cover property ($rose(new_hi));
  c_init: cover property ($rose(init_out));
endmodule : pwp_link_checker

// ===== pwp_link_if.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Parallel word lines between the port and the user device.
// ----------------------------------------------------------------
interface pwp_link_if;
  logic [15:0] data_out;
  logic [1:0] func_out;
  logic new_word;
  logic new_hi;
  logic new_lo;
  logic data_taken;
  logic init_out;
  logic [15:0] data_in;
  logic req_a;
  logic req_b;

  modport port_end (
    output data_out,
    output func_out,
    output new_word,
    output new_hi,
    output new_lo,
    output data_taken,
    output init_out,
    input data_in,
    input req_a,
    input req_b
  );

  modport user_end (
    input data_out,
    input func_out,
    input new_word,
    input new_hi,
    input new_lo,
    input data_taken,
    input init_out,
    output data_in,
    output req_a,
    output req_b
  );
endinterface : pwp_link_if

// ===== pwp_pkg.sv
package pwp_pkg;

  // ----------------------------------------------------------------
  // State of the documented port end.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] out_q;
    logic [1:0] func_q;
    logic [4:0][5:0] cnt_q;
    logic [4:0] strobe_q;
    logic [15:0] in_q;
    logic req_a_q;
    logic req_b_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
  } pwp_dev_state_type;

  // ----------------------------------------------------------------
  // State of the user device end.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] word_q;
    logic [4:0] prev_q;
    logic new_word_q;
    logic new_hi_q;
    logic new_lo_q;
    logic taken_q;
    logic init_q;
    logic [1:0] func_q;
    logic [15:0] din_q;
    logic req_a_q;
    logic req_b_q;
  } pwp_usr_state_type;

endpackage : pwp_pkg

// ===== pwp_port_dev.sv
`timescale 1ns/1ns
`include "pwp_defines.svh"
// ----------------------------------------------------------------
// Parallel word port, compatibility mode.
// Host side: a simple word bus with a byte qualifier.
// Link side: sixteen data lines each way, strobes, requests.
// ----------------------------------------------------------------
module pwp_port_dev
  import pwp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic compat_mode,
  input wire logic [2:0] host_addr,
  input wire logic host_wr,
  input wire logic host_byte,
  input wire logic [15:0] host_wdata,
  input wire logic host_rd,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  pwp_link_if.port_end link
);

  pwp_dev_state_type s_q;
  pwp_dev_state_type s_d;
  logic [2:0] wr_addr;
  logic lane_write;
  logic [15:0] csr_view;

  // ----------------------------------------------------------------
  // Address handling for writes.
  // ----------------------------------------------------------------
  // Only a byte write to the output buffer in compatibility mode keeps
  // address bit zero; every other write loses it and acts on a word.
  assign lane_write = host_byte && compat_mode
    && (host_addr[2:1] == 2'(`PWP_OFF_OUTBUF >> 1));
  assign wr_addr = lane_write ? host_addr : {host_addr[2:1], 1'b0};

  // ----------------------------------------------------------------
  // Status view.
  // ----------------------------------------------------------------
  // The initialize bit is a command only and always reads back zero,
  // so software that leaves it clear sees a stable register.
  always_comb
  begin
    csr_view = `PWP_CSR_RST;
    csr_view[`PWP_CSR_FUNC0] = s_q.func_q[0];
    csr_view[`PWP_CSR_FUNC1] = s_q.func_q[1];
    csr_view[`PWP_CSR_REQA] = s_q.req_a_q;
    csr_view[`PWP_CSR_REQB] = s_q.req_b_q;
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;

    // Input lines and requests are taken each cycle as synchronous.
    s_d.in_q = link.data_in;
    s_d.req_a_q = link.req_a;
    s_d.req_b_q = link.req_b;

    // Every strobe counter runs down by one toward zero.
    for (int i = 0; i < `PWP_NSTB; i++)
    begin
      if (s_q.cnt_q[i] != '0)
      begin
        s_d.cnt_q[i] = s_q.cnt_q[i] - `PWP_CNT_W'(1);
      end
    end

    // Host writes. A new write while a strobe still runs restarts it,
    // so the user device sees one stretched pulse, never a short one.
    if (host_wr)
    begin
      unique case (wr_addr)
        `PWP_OFF_CSR:
        begin
          s_d.func_q = {host_wdata[`PWP_CSR_FUNC1], host_wdata[`PWP_CSR_FUNC0]};
          if (host_wdata[`PWP_CSR_INIT])
          begin
            s_d.cnt_q[`PWP_STB_INIT] = `PWP_CNT_W'(`PWP_STROBE_CYC);
          end
        end
        `PWP_OFF_OUTBUF:
        begin
          s_d.out_q = host_wdata;
          s_d.cnt_q[`PWP_STB_NDR] = `PWP_CNT_W'(`PWP_STROBE_CYC);
        end
        3'h3:
        begin
          // Upper lane in compatibility mode.
          s_d.out_q[15:8] = host_wdata[15:8];
          s_d.cnt_q[`PWP_STB_HI] = `PWP_CNT_W'(`PWP_STROBE_CYC);
        end
        default:
        begin
          // The input buffer is read-only; other writes are dropped.
        end
      endcase
      // Lower lane byte write in compatibility mode.
      if (lane_write && !host_addr[0])
      begin
        s_d.out_q = s_q.out_q;
        s_d.out_q[7:0] = host_wdata[7:0];
        s_d.cnt_q[`PWP_STB_NDR] = s_q.cnt_q[`PWP_STB_NDR] - 
          ((s_q.cnt_q[`PWP_STB_NDR] != '0) ? `PWP_CNT_W'(1) : `PWP_CNT_W'(0));
        s_d.cnt_q[`PWP_STB_LO] = `PWP_CNT_W'(`PWP_STROBE_CYC);
      end
    end

    // Host reads answer one cycle later; a read of the input buffer
    // tells the user device that its word has been taken.
    s_d.rvalid_q = host_rd;
    if (host_rd)
    begin
      unique case ({host_addr[2:1], 1'b0})
        `PWP_OFF_CSR:
        begin
          s_d.rdata_q = csr_view;
        end
        `PWP_OFF_OUTBUF:
        begin
          s_d.rdata_q = s_q.out_q;
        end
        `PWP_OFF_INBUF:
        begin
          s_d.rdata_q = s_q.in_q;
          s_d.cnt_q[`PWP_STB_XMTD] = `PWP_CNT_W'(`PWP_STROBE_CYC);
        end
        default:
        begin
          s_d.rdata_q = 16'h0000;
        end
      endcase
    end
    else
    begin
      s_d.rdata_q = 16'h0000;
    end

    // A strobe is high exactly while its counter is non-zero, which is
    // a fixed one microsecond with no setting to change it.
    for (int i = 0; i < `PWP_NSTB; i++)
    begin
      s_d.strobe_q[i] = (s_d.cnt_q[i] != '0);
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // No lock is held between a read and a following write; the host
  // must use plain moves to these registers.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops.
  // ----------------------------------------------------------------
  assign link.data_out = s_q.out_q;
  assign link.func_out = s_q.func_q;
  assign link.new_word = s_q.strobe_q[`PWP_STB_NDR];
  assign link.new_hi = s_q.strobe_q[`PWP_STB_HI];
  assign link.new_lo = s_q.strobe_q[`PWP_STB_LO];
  assign link.data_taken = s_q.strobe_q[`PWP_STB_XMTD];
  assign link.init_out = s_q.strobe_q[`PWP_STB_INIT];
  assign host_rdata = s_q.rdata_q;
  assign host_rvalid = s_q.rvalid_q;

endmodule : pwp_port_dev

// ===== pwp_user_end.sv
`timescale 1ns/1ns
`include "pwp_defines.svh"
// ----------------------------------------------------------------
// User device end: catches words on the strobes, returns input data.
// ----------------------------------------------------------------
module pwp_user_end
  import pwp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  pwp_link_if.user_end link,
  input wire logic [15:0] usr_data_in,
  input wire logic usr_req_a,
  input wire logic usr_req_b,
  output logic [15:0] usr_word,
  output logic usr_new_word,
  output logic usr_new_hi,
  output logic usr_new_lo,
  output logic usr_taken,
  output logic usr_init,
  output logic [1:0] usr_func
);

  pwp_usr_state_type s_q;
  pwp_usr_state_type s_d;
  logic [4:0] stb;
  logic [4:0] rise;

  // Strobes are level pulses; only their rising edge marks an event.
  assign stb = {link.init_out, link.data_taken, link.new_lo, link.new_hi, link.new_word};
  assign rise = stb & ~s_q.prev_q;

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.prev_q = stb;
    s_d.new_word_q = rise[`PWP_STB_NDR];
    s_d.new_hi_q = rise[`PWP_STB_HI];
    s_d.new_lo_q = rise[`PWP_STB_LO];
    s_d.taken_q = rise[`PWP_STB_XMTD];
    s_d.init_q = rise[`PWP_STB_INIT];
    s_d.func_q = link.func_out;
    if (rise[`PWP_STB_NDR])
    begin
      s_d.word_q = link.data_out;
    end
    if (rise[`PWP_STB_HI])
    begin
      s_d.word_q[15:8] = link.data_out[15:8];
    end
    if (rise[`PWP_STB_LO])
    begin
      s_d.word_q[7:0] = link.data_out[7:0];
    end
    // Input lines and requests are driven from flops to avoid glitches.
    s_d.din_q = usr_data_in;
    s_d.req_a_q = usr_req_a;
    s_d.req_b_q = usr_req_b;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign link.data_in = s_q.din_q;
  assign link.req_a = s_q.req_a_q;
  assign link.req_b = s_q.req_b_q;
  assign usr_word = s_q.word_q;
  assign usr_new_word = s_q.new_word_q;
  assign usr_new_hi = s_q.new_hi_q;
  assign usr_new_lo = s_q.new_lo_q;
  assign usr_taken = s_q.taken_q;
  assign usr_init = s_q.init_q;
  assign usr_func = s_q.func_q;

endmodule : pwp_user_end

// ===== tb_parallel_word_port_compat.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench: host writes and reads, user end captures and returns words.
// ----------------------------------------------------------------
module tb_parallel_word_port_compat;
  logic sys_clk;
  logic rst_n;
  logic compat_mode;
  logic host_wr;
  logic host_rd;
  logic host_byte;
  logic host_rvalid;
  logic usr_req_a;
  logic usr_req_b;
  logic usr_new_word;
  logic usr_new_hi;
  logic usr_new_lo;
  logic [1:0] usr_func;
  logic [2:0] host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic [15:0] usr_data_in;
  logic [15:0] usr_word;
  logic [15:0] exp_out;
  logic [15:0] r;
  logic [15:0] exp_word[$];
  logic [15:0] exp_rd[$];
  logic [2:0] exp_kind[$];
  logic [2:0] kind_exp;
  logic usr_taken;
  logic usr_init;
  int taken_seen = 0;
  int init_seen = 0;
  int fail_count = 0;
  int cmp_count = 0;

  pwp_link_if link_if();
  pwp_port_dev pwp_port_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .compat_mode(compat_mode), .host_addr(host_addr), .host_wr(host_wr),
    .host_byte(host_byte), .host_wdata(host_wdata), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .link(link_if.port_end));
  pwp_user_end pwp_user_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link_if.user_end), .usr_data_in(usr_data_in), .usr_req_a(usr_req_a),
    .usr_req_b(usr_req_b), .usr_word(usr_word), .usr_new_word(usr_new_word),
    .usr_new_hi(usr_new_hi), .usr_new_lo(usr_new_lo), .usr_taken(usr_taken),
    .usr_init(usr_init),
    .usr_func(usr_func));
  pwp_link_checker pwp_link_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .data_out(link_if.data_out), .new_word(link_if.new_word), .new_hi(link_if.new_hi),
    .new_lo(link_if.new_lo), .data_taken(link_if.data_taken), .init_out(link_if.init_out));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One host access; the long tail lets every 50-cycle strobe finish,
  // since a new write inside a pulse would only stretch it.
  task automatic acc(input logic w, input logic [2:0] a, input logic b,
                     input logic [15:0] d, input logic [15:0] e);
    if (!w)
      exp_rd.push_back(e);
    host_addr = a;
    host_byte = b;
    host_wdata = d;
    host_wr = w;
    host_rd = !w;
    @(posedge sys_clk);
    #2;
    host_wr = 1'b0;
    host_rd = 1'b0;
    repeat (55) @(posedge sys_clk);
    #2;
  endtask : acc

  task automatic report_and_stop;
    chk(16'(exp_word.size() + exp_rd.size() + exp_kind.size()), 16'h0000, "never seen");
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Free-running 50 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Results are sampled mid-cycle, where the registered pulses have settled.
  always @(negedge sys_clk)
  begin
    if (usr_new_word === 1'b1 || usr_new_hi === 1'b1 || usr_new_lo === 1'b1)
    begin
      chk(usr_word, exp_word.size() > 0 ? exp_word.pop_front() : 16'hXXXX, "word");
      // An empty queue expects all three strobes, which can never match.
      kind_exp = exp_kind.size() > 0 ? exp_kind.pop_front() : 3'h7;
      chk({13'h0000, usr_new_lo, usr_new_hi, usr_new_word}, {13'h0000, kind_exp}, "kind");
    end
    if (usr_taken === 1'b1)
      taken_seen++;
    if (usr_init === 1'b1)
      init_seen++;
    if (host_rvalid === 1'b1)
      chk(host_rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 16'hXXXX, "read");
  end

  initial
  begin
    rst_n = 1'b0;
    compat_mode = 1'b1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_byte = 1'b0;
    host_addr = 3'h0;
    host_wdata = 16'h0000;
    usr_data_in = 16'h0000;
    usr_req_a = 1'b0;
    usr_req_b = 1'b0;
    exp_out = 16'h0000;
    r = 16'($urandom(32'h6CD8));
    repeat (5) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    // Word write, both byte lanes, then a byte write outside compat mode.
    for (int i = 0; i < 4; i++)
    begin
      r = 16'($urandom);
      compat_mode = (i != 3);
      if (i == 1)
        exp_out[15:8] = r[15:8];
      else if (i == 2)
        exp_out[7:0] = r[7:0];
      else
        exp_out = r;
      exp_word.push_back(exp_out);
      exp_kind.push_back((i == 1) ? 3'h2 : ((i == 2) ? 3'h4 : 3'h1));
      acc(1'b1, (i == 0 || i == 2) ? 3'h2 : 3'h3, i != 0, r, 16'h0000);
    end
    compat_mode = 1'b1;
    $display("test output lanes done");
    // A byte write to the odd control address still sets the whole word.
    acc(1'b1, 3'h1, 1'b1, {14'h0000, r[1:0]}, 16'h0000);
    chk({14'h0000, usr_func}, {14'h0000, r[1:0]}, "function lines");
    // The initialize bit exists only in the newer port, so compatibility
    // mode is left while it is set; pwp_port_dev acts on it in either mode.
    compat_mode = 1'b0;
    acc(1'b1, 3'h0, 1'b0, {14'h0000, r[1:0]} | 16'h0008, 16'h0000);
    compat_mode = 1'b1;
    chk(16'(init_seen), 16'h0001, "initialize pulses");
    $display("test control word done");
    usr_data_in = 16'($urandom);
    usr_req_a = 1'b1;
    usr_req_b = r[0];
    repeat (4) @(posedge sys_clk);
    #2;
    acc(1'b0, 3'h4, 1'b0, 16'h0000, usr_data_in);
    acc(1'b0, 3'h0, 1'b0, 16'h0000, {usr_req_b, 7'h00, usr_req_a, 5'h00, r[1:0]});
    acc(1'b0, 3'h6, 1'b0, 16'h0000, 16'h0000);
    chk(16'(taken_seen), 16'h0001, "acknowledge pulses");
    // A write to the read-only input buffer must leave the output word alone.
    acc(1'b1, 3'h4, 1'b0, ~exp_out, 16'h0000);
    acc(1'b0, 3'h2, 1'b0, 16'h0000, exp_out);
    $display("test input side done");
    report_and_stop();
  end
endmodule : tb_parallel_word_port_compat
